// file: hdl/ted_device.sv
// Tap detector end: registers, single and double tap qualification, axis report.
`timescale 1ns/1ps
module ted_device
  import ted_pkg::*;
#(
  parameter int SAMPLE_W  = 16,
  parameter int THR_SHIFT = 4
) (
  // Clock and reset.
  input  wire logic                     CORE_CLK,
  input  wire logic                     RESET,
  // Register link.
  ted_link_if.dev                       LNK,
  // Acceleration samples, index 2 is x, 1 is y, 0 is z.
  input  wire logic                     SAMPLE_VALID,
  input  wire logic                     ODR_VALID,
  input  wire logic [2:0][SAMPLE_W-1:0] ACCEL,
  // Tap events.
  output logic                          SINGLE_TAP,
  output logic                          DOUBLE_TAP
);
  import ted_pkg::*;

  typedef struct packed {
    logic [7:0]                threshold;
    logic [7:0]                max_duration;
    logic [7:0]                latency;
    logic [7:0]                window;
    logic [7:0]                axis_control;
    logic [7:0]                event_enable;
    logic [2:0]                first_axis;
    logic [2:0]                tap_axis;
    logic [2:0]                tap_sign;
    ted_tap_st_t               st;
    logic [7:0]                cnt;
    logic [2:0]                cap_axis;
    logic [2:0]                cap_sign;
    logic [2:0][SAMPLE_W-1:0]  prev;
    logic [DATA_W-1:0]         rdata;
    logic                      rvalid;
    logic                      ev_single;
    logic                      ev_double;
  } ted_dev_state_t;

  ted_dev_state_t q_ff;
  ted_dev_state_t nxt_q;

  logic [2:0]                hit;
  logic [2:0]                neg;
  logic [2:0]                pick;
  logic [2:0][SAMPLE_W-1:0]  val;
  logic                      improved;
  logic                      step;
  logic                      any_hit;
  logic                      dbl_on;
  logic                      fire_s;
  logic                      fire_d;

  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] v);
    magnitude = v[SAMPLE_W-1] ? SAMPLE_W'(~v + 1'b1) : v;
  endfunction

  function automatic logic over_thr(input logic [SAMPLE_W-1:0] v, input logic [7:0] thr);
    over_thr = (magnitude(v) >> THR_SHIFT) > SAMPLE_W'(thr);
  endfunction

  function automatic logic [7:0] incr(input logic [7:0] c);
    incr = (c == 8'hFF) ? c : 8'(c + 8'h01);
  endfunction

  assign LNK.reg_rdata  = q_ff.rdata;
  assign LNK.reg_rvalid = q_ff.rvalid;
  assign LNK.tap_single = q_ff.ev_single;
  assign LNK.tap_double = q_ff.ev_double;
  assign SINGLE_TAP     = q_ff.ev_single;
  assign DOUBLE_TAP     = q_ff.ev_double;

  always_comb begin
    nxt_q           = q_ff;
    nxt_q.rvalid    = 1'b0;
    nxt_q.ev_single = 1'b0;
    nxt_q.ev_double = 1'b0;
    fire_s          = 1'b0;
    fire_d          = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and reads.
    if (LNK.reg_wr) begin
      case (LNK.reg_addr)
        ADR_TAP_THRESHOLD:     nxt_q.threshold    = LNK.reg_wdata;
        ADR_TAP_MAX_DURATION:  nxt_q.max_duration = LNK.reg_wdata;
        ADR_TAP_LATENCY:       nxt_q.latency      = LNK.reg_wdata;
        ADR_SECOND_TAP_WINDOW: nxt_q.window       = LNK.reg_wdata;
        ADR_TAP_AXIS_CONTROL:  nxt_q.axis_control = LNK.reg_wdata;
        ADR_EVENT_ENABLE:      nxt_q.event_enable = LNK.reg_wdata;
        default: begin
        end
      endcase
    end
    if (LNK.reg_rd) begin
      nxt_q.rvalid = 1'b1;
      case (LNK.reg_addr)
        ADR_TAP_THRESHOLD:     nxt_q.rdata = q_ff.threshold;
        ADR_TAP_MAX_DURATION:  nxt_q.rdata = q_ff.max_duration;
        ADR_TAP_LATENCY:       nxt_q.rdata = q_ff.latency;
        ADR_SECOND_TAP_WINDOW: nxt_q.rdata = q_ff.window;
        ADR_TAP_AXIS_CONTROL:  nxt_q.rdata = q_ff.axis_control;
        ADR_EVENT_ENABLE:      nxt_q.rdata = q_ff.event_enable;
        // Reading leaves the report untouched.
        ADR_FIRST_AXIS_STATUS: nxt_q.rdata = {5'h00, q_ff.first_axis};
        ADR_TAP_SIGN_AXIS:     nxt_q.rdata = {1'b0, q_ff.tap_sign, 1'b0, q_ff.tap_axis};
        default:               nxt_q.rdata = 8'h00;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample qualification.
    improved = q_ff.axis_control[AXCTL_IMPROVED];
    step     = improved ? ODR_VALID : SAMPLE_VALID;
    for (int i = 0; i < 3; i++) begin
      // Improved mode looks at the change between output-rate samples.
      val[i] = improved ? SAMPLE_W'(ACCEL[i] - q_ff.prev[i]) : ACCEL[i];
      hit[i] = q_ff.axis_control[i] && over_thr(val[i], q_ff.threshold);
      neg[i] = val[i][SAMPLE_W-1];
    end
    if (ODR_VALID) begin
      nxt_q.prev = ACCEL;
    end
    any_hit = |hit;
    // Simultaneous crossings report one axis, x before y before z.
    if (hit[AX_X]) begin
      pick = 3'b100;
    end else if (hit[AX_Y]) begin
      pick = 3'b010;
    end else begin
      pick = hit & 3'b001;
    end
    dbl_on = q_ff.event_enable[EN_DOUBLE] && (q_ff.latency != 8'h00)
             && (q_ff.window != 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Tap sequence.
    case (q_ff.st)
      TS_IDLE: begin
        if (step && any_hit) begin
          nxt_q.cap_axis = pick;
          nxt_q.cap_sign = neg & pick;
          nxt_q.cnt      = 8'h01;
          nxt_q.st       = TS_TAP1;
        end
      end
      TS_TAP1: begin
        if (step) begin
          if (any_hit) begin
            if (q_ff.cnt >= q_ff.max_duration) begin
              nxt_q.st = TS_HOLD;
            end else begin
              nxt_q.cnt = incr(q_ff.cnt);
            end
          end else if (dbl_on) begin
            nxt_q.cnt = 8'h00;
            nxt_q.st  = TS_LAT;
          end else begin
            fire_s   = 1'b1;
            nxt_q.st = TS_IDLE;
          end
        end
      end
      TS_LAT: begin
        if (step) begin
          if (any_hit && q_ff.axis_control[AXCTL_SUPPRESS]) begin
            fire_s   = 1'b1;
            nxt_q.st = TS_HOLD;
          end else if (incr(q_ff.cnt) >= q_ff.latency) begin
            nxt_q.cnt = 8'h00;
            nxt_q.st  = TS_WIN;
          end else begin
            nxt_q.cnt = incr(q_ff.cnt);
          end
        end
      end
      TS_WIN: begin
        if (step) begin
          if (any_hit && q_ff.cnt == 8'h00) begin
            fire_s   = 1'b1;
            nxt_q.st = TS_HOLD;
          end else if (any_hit) begin
            nxt_q.cnt = 8'h01;
            nxt_q.st  = TS_TAP2;
          end else if (incr(q_ff.cnt) >= q_ff.window) begin
            fire_s   = 1'b1;
            nxt_q.st = TS_IDLE;
          end else begin
            nxt_q.cnt = incr(q_ff.cnt);
          end
        end
      end
      TS_TAP2: begin
        if (step) begin
          if (any_hit) begin
            if (q_ff.cnt >= q_ff.max_duration) begin
              fire_s   = 1'b1;
              nxt_q.st = TS_HOLD;
            end else begin
              nxt_q.cnt = incr(q_ff.cnt);
            end
          end else begin
            fire_s   = 1'b1;
            fire_d   = 1'b1;
            nxt_q.st = TS_IDLE;
          end
        end
      end
      TS_HOLD: begin
        // A rejected or overlong tap must fall before a new one can start.
        if (step && !any_hit) begin
          nxt_q.st = TS_IDLE;
        end
      end
      default: begin
        nxt_q.st = TS_IDLE;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Event outputs and axis report.
    nxt_q.ev_single = fire_s && q_ff.event_enable[EN_SINGLE];
    nxt_q.ev_double = fire_d;
    if (nxt_q.ev_single || nxt_q.ev_double) begin
      nxt_q.first_axis = q_ff.cap_axis & q_ff.axis_control[2:0];
      nxt_q.tap_axis   = q_ff.cap_axis & q_ff.axis_control[2:0];
      for (int i = 0; i < 3; i++) begin
        if (q_ff.axis_control[i]) begin
          nxt_q.tap_sign[i] = q_ff.cap_sign[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      q_ff <= '{
        threshold:    REG_RESET,
        max_duration: REG_RESET,
        latency:      REG_RESET,
        window:       REG_RESET,
        axis_control: REG_RESET,
        event_enable: REG_RESET,
        st:           TS_IDLE,
        default:      '0
      };
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

// file: hdl/ted_pkg.sv
// Shared register map, field positions and state types of the tap event detector.
package ted_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [5:0] ADR_TAP_THRESHOLD     = 6'h1D;
  localparam logic [5:0] ADR_TAP_MAX_DURATION  = 6'h21;
  localparam logic [5:0] ADR_TAP_LATENCY       = 6'h22;
  localparam logic [5:0] ADR_SECOND_TAP_WINDOW = 6'h23;
  localparam logic [5:0] ADR_TAP_AXIS_CONTROL  = 6'h2A;
  localparam logic [5:0] ADR_FIRST_AXIS_STATUS = 6'h2B;
  localparam logic [5:0] ADR_EVENT_ENABLE      = 6'h2E;
  localparam logic [5:0] ADR_TAP_SIGN_AXIS     = 6'h3A;

  // Reset value of every register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Axis index inside three-bit axis fields: x, y, z.
  localparam int AX_Z = 0;
  localparam int AX_Y = 1;
  localparam int AX_X = 2;

  // Field positions.
  localparam int AXCTL_SUPPRESS = 3;
  localparam int AXCTL_IMPROVED = 4;
  localparam int EN_DOUBLE      = 5;
  localparam int EN_SINGLE      = 6;
  localparam int SIGN_LSB       = 4;

  // Recommended lower bounds for tuning.
  localparam logic [7:0] REC_DURATION  = 8'h10;
  localparam logic [7:0] REC_LATENCY   = 8'h10;
  localparam logic [7:0] REC_WINDOW    = 8'h40;
  localparam logic [7:0] REC_THRESHOLD = 8'h30;

  typedef enum logic [2:0] {
    TS_IDLE, TS_TAP1, TS_LAT, TS_WIN, TS_TAP2, TS_HOLD
  } ted_tap_st_t;

  typedef enum logic {
    HS_IDLE, HS_WAIT
  } ted_host_st_t;

endpackage

// file: hdl/ted_link_if.sv
// Register link between the host end and the tap detector end.
`timescale 1ns/1ps
interface ted_link_if;
  import ted_pkg::*;

  logic                reg_wr;
  logic                reg_rd;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic [DATA_W-1:0]   reg_rdata;
  logic                reg_rvalid;
  logic                tap_single;
  logic                tap_double;

  modport dev (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, tap_single, tap_double
  );

  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_rvalid, tap_single, tap_double
  );

endinterface

// file: hdl/ted_host.sv
// Host end: register commands onto the link and one tap report fetch per event cycle, so a paired single and double share one.
`timescale 1ns/1ps
module ted_host
  import ted_pkg::*;
(
  // Clock and reset.
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET,
  // Register link.
  ted_link_if.host                   LNK,
  // User command port.
  input  wire logic                  CMD_VALID,
  input  wire logic                  CMD_WRITE,
  input  wire logic [ADDR_W-1:0]     CMD_ADDR,
  input  wire logic [DATA_W-1:0]     CMD_WDATA,
  output logic                       CMD_READY,
  output logic                       RSP_VALID,
  output logic [DATA_W-1:0]          RSP_DATA,
  // Tap report and configuration warning.
  output logic                       TAP_VALID,
  output logic                       TAP_DOUBLE,
  output logic [DATA_W-1:0]          TAP_INFO,
  output logic                       CFG_WARN
);
  import ted_pkg::*;

  typedef struct packed {
    ted_host_st_t       st;
    logic               wr;
    logic               rd;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [7:0]         lat_shadow;
    logic [7:0]         win_shadow;
    logic               pend_s;
    logic               pend_d;
    logic               auto_rd;
    logic               kind_d;
    logic               ready;
    logic               rsp_v;
    logic [DATA_W-1:0]  rsp_data;
    logic               tap_v;
    logic               tap_d;
    logic [DATA_W-1:0]  tap_info;
    logic               warn;
  } ted_host_state_t;

  ted_host_state_t q_ff;
  ted_host_state_t nxt_q;
  logic [DATA_W-1:0] wval;

  function automatic logic below_rec(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    case (a)
      ADR_TAP_MAX_DURATION:  below_rec = d <= REC_DURATION;
      ADR_TAP_LATENCY:       below_rec = d <= REC_LATENCY;
      ADR_SECOND_TAP_WINDOW: below_rec = d <= REC_WINDOW;
      ADR_TAP_THRESHOLD:     below_rec = d <= REC_THRESHOLD;
      default:               below_rec = 1'b0;
    endcase
  endfunction

  assign LNK.reg_wr    = q_ff.wr;
  assign LNK.reg_rd    = q_ff.rd;
  assign LNK.reg_addr  = q_ff.addr;
  assign LNK.reg_wdata = q_ff.wdata;
  assign CMD_READY     = q_ff.ready;
  assign RSP_VALID     = q_ff.rsp_v;
  assign RSP_DATA      = q_ff.rsp_data;
  assign TAP_VALID     = q_ff.tap_v;
  assign TAP_DOUBLE    = q_ff.tap_d;
  assign TAP_INFO      = q_ff.tap_info;
  assign CFG_WARN      = q_ff.warn;

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.wr    = 1'b0;
    nxt_q.rd    = 1'b0;
    nxt_q.rsp_v = 1'b0;
    nxt_q.tap_v = 1'b0;
    nxt_q.warn  = 1'b0;
    wval        = CMD_WDATA;
    if (LNK.tap_single) begin
      nxt_q.pend_s = 1'b1;
    end
    if (LNK.tap_double) begin
      nxt_q.pend_d = 1'b1;
    end

    case (q_ff.st)
      HS_IDLE: begin
        if (q_ff.pend_s || q_ff.pend_d) begin
          // Fetch sign and axis before the event is handed on.
          nxt_q.rd      = 1'b1;
          nxt_q.addr    = ADR_TAP_SIGN_AXIS;
          nxt_q.auto_rd = 1'b1;
          nxt_q.kind_d  = q_ff.pend_d || LNK.tap_double;
          nxt_q.pend_s  = LNK.tap_single;
          nxt_q.pend_d  = LNK.tap_double;
          nxt_q.st      = HS_WAIT;
        end else if (CMD_VALID && q_ff.ready) begin
          nxt_q.addr = CMD_ADDR;
          if (CMD_WRITE) begin
            if (CMD_ADDR == ADR_EVENT_ENABLE && CMD_WDATA[EN_DOUBLE]
                && (q_ff.lat_shadow == 8'h00 || q_ff.win_shadow == 8'h00)) begin
              wval[EN_DOUBLE] = 1'b0;
              nxt_q.warn      = 1'b1;
            end
            if (below_rec(CMD_ADDR, CMD_WDATA)) begin
              nxt_q.warn = 1'b1;
            end
            if (CMD_ADDR == ADR_TAP_LATENCY) begin
              nxt_q.lat_shadow = CMD_WDATA;
            end
            if (CMD_ADDR == ADR_SECOND_TAP_WINDOW) begin
              nxt_q.win_shadow = CMD_WDATA;
            end
            nxt_q.wr    = 1'b1;
            nxt_q.wdata = wval;
          end else begin
            nxt_q.rd      = 1'b1;
            nxt_q.auto_rd = 1'b0;
            nxt_q.st      = HS_WAIT;
          end
        end
      end
      HS_WAIT: begin
        if (LNK.reg_rvalid) begin
          if (q_ff.auto_rd) begin
            nxt_q.tap_v    = 1'b1;
            nxt_q.tap_d    = q_ff.kind_d;
            nxt_q.tap_info = LNK.reg_rdata;
          end else begin
            nxt_q.rsp_v    = 1'b1;
            nxt_q.rsp_data = LNK.reg_rdata;
          end
          nxt_q.st = HS_IDLE;
        end
      end
      default: begin
        nxt_q.st = HS_IDLE;
      end
    endcase
    nxt_q.ready = (nxt_q.st == HS_IDLE) && !nxt_q.pend_s && !nxt_q.pend_d;
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      q_ff <= '{st: HS_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

// file: tb/ted_sva.sv
// Link checker for the tap event detector, watching both ends of the register link.
`timescale 1ns/1ps
module ted_sva
  import ted_pkg::*;
(
  // Clock and reset.
  input wire logic              CORE_CLK,
  input wire logic              RESET,
  // Link signals.
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              tap_single,
  input wire logic              tap_double
);
  logic [7:0] lat_ff;
  logic [7:0] win_ff;
  logic [7:0] en_ff;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////
  // Shadows of the registers as they were written over the link.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      lat_ff <= 8'h00;
      win_ff <= 8'h00;
      en_ff  <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADR_TAP_LATENCY) begin
        lat_ff <= reg_wdata;
      end
      if (reg_addr == ADR_SECOND_TAP_WINDOW) begin
        win_ff <= reg_wdata;
      end
      if (reg_addr == ADR_EVENT_ENABLE) begin
        en_ff <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered one cycle later");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read strobe");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data changed outside a read answer");
  a_read_spacing: assert property (reg_rd |=> !reg_rd [*2])
    else $error("second read issued while one is in flight");
  a_strobe_excl: assert property (!(reg_wr && reg_rd))
    else $error("write and read strobes together");
  a_single_pulse: assert property (tap_single |=> !tap_single)
    else $error("single tap event longer than one cycle");
  a_single_enabled: assert property (tap_single |-> en_ff[EN_SINGLE])
    else $error("single tap event while single detection is off");
  a_double_enabled: assert property (
    tap_double |-> en_ff[EN_DOUBLE] && lat_ff != 8'h00 && win_ff != 8'h00)
    else $error("double tap event while double detection cannot run");
  a_double_paired: assert property (tap_double && en_ff[EN_SINGLE] |-> tap_single)
    else $error("double tap event without its single tap event");
  a_double_cfg: assert property (
    reg_wr && reg_addr == ADR_EVENT_ENABLE && reg_wdata[EN_DOUBLE]
    |-> lat_ff != 8'h00 && win_ff != 8'h00)
    else $error("double enable sent before latency and window are set");

  c_double: cover property (tap_double);
  c_single: cover property (tap_single && !tap_double);
  c_read: cover property (reg_rd ##1 reg_rvalid);
endmodule

// file: tb/tb.sv
// Self-checking testbench joining the host end and the tap detector end.
`timescale 1ns/1ps
module tb;
  import ted_pkg::*;
  logic                     core_clk = 1'b0;
  logic                     reset = 1'b1;
  logic                     cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic [ADDR_W-1:0]        cmd_addr;
  logic [DATA_W-1:0]        cmd_wdata, rsp_data, tap_info, rd_val;
  logic                     tap_valid, tap_double, cfg_warn;
  logic                     sample_valid, odr_valid, single_tap, double_tap;
  logic [2:0][15:0]         accel;
  int                       miscompares = 0;
  int                       tests_run = 0;
  int                       n_single = 0;
  int                       n_double = 0;
  int                       n_pair = 0;
  int                       n_warn = 0;
  int                       n_tap = 0;
  int                       base_s, base_d, base_p, base_w, base_t;

  ted_link_if lnk ();
  ted_device i_ted_device (.CORE_CLK(core_clk), .RESET(reset), .LNK(lnk),
    .SAMPLE_VALID(sample_valid), .ODR_VALID(odr_valid), .ACCEL(accel),
    .SINGLE_TAP(single_tap), .DOUBLE_TAP(double_tap));
  ted_host i_ted_host (.CORE_CLK(core_clk), .RESET(reset), .LNK(lnk),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .TAP_VALID(tap_valid), .TAP_DOUBLE(tap_double),
    .TAP_INFO(tap_info), .CFG_WARN(cfg_warn));
  ted_sva i_ted_sva (.CORE_CLK(core_clk), .RESET(reset), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
    .tap_single(lnk.tap_single), .tap_double(lnk.tap_double));

  always #20 core_clk = ~core_clk;

  // Event counters are updated by non-blocking assignment so snapshots never race them.
  always @(posedge core_clk) begin
    n_single <= n_single + int'(single_tap);
    n_double <= n_double + int'(double_tap);
    n_pair   <= n_pair + int'(single_tap && double_tap);
    n_warn   <= n_warn + int'(cfg_warn);
    n_tap    <= n_tap + int'(tap_valid);
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int   n;
    logic ok;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    ok = (cmd_ready === 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    // A command that is never taken or never answered counts as a mismatch.
    ok = ok && (wr || rsp_valid === 1'b1);
    if (!ok) begin
      miscompares++;
      $display("[FAIL] command handshake expected 1 seen 0");
    end
    rd_val = rsp_data;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cmd(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    cmd(1'b0, a, 8'h00);
    chk(what, exp, rd_val & m);
  endtask

  task automatic step(input logic [15:0] x, input logic [15:0] z, input logic odr);
    @(posedge core_clk);
    sample_valid <= !odr;
    odr_valid    <= odr;
    accel        <= {x, 16'h0000, z};
    @(posedge core_clk);
    sample_valid <= 1'b0;
    odr_valid    <= 1'b0;
  endtask

  task automatic hits(input logic [15:0] x, input logic [15:0] z, input int n);
    repeat (n) step(x, z, 1'b0);
  endtask

  task automatic mark();
    base_s = n_single;
    base_d = n_double;
    base_p = n_pair;
    base_w = n_warn;
    base_t = n_tap;
  endtask

  task automatic seq(input logic [15:0] x, input logic [15:0] z, input int l1, input int gap,
                     input int l2);
    mark();
    hits(x, z, l1);
    hits(16'h0000, 16'h0000, gap);
    hits(x, z, l2);
    hits(16'h0000, 16'h0000, 90);
  endtask

  task automatic expect_ev(input logic [7:0] s, input logic [7:0] d);
    repeat (12) @(posedge core_clk);
    chk("single events", s, 8'(n_single - base_s));
    chk("double events", d, 8'(n_double - base_d));
    // Paired events come out in one cycle, so they make a single report.
    chk("tap reports", (s > d) ? s : d, 8'(n_tap - base_t));
  endtask

  ////////////////////////////////////////////////////////////
  task automatic s_regs();
    mark();
    rd_chk("status after reset", ADR_FIRST_AXIS_STATUS, 8'hFF, REG_RESET);
    wr(ADR_EVENT_ENABLE, 8'h60);
    rd_chk("double held off", ADR_EVENT_ENABLE, 8'hFF, 8'h40);
    wr(ADR_TAP_THRESHOLD, 8'h20);
    rd_chk("low threshold kept", ADR_TAP_THRESHOLD, 8'hFF, 8'h20);
    wr(ADR_FIRST_AXIS_STATUS, 8'hFF);
    rd_chk("status read only", ADR_FIRST_AXIS_STATUS, 8'hFF, 8'h00);
    rd_chk("unmapped read", 6'h3F, 8'hFF, 8'h00);
    chk("warnings", 8'h02, 8'(n_warn - base_w));
    wr(ADR_TAP_THRESHOLD, 8'h31);
    wr(ADR_TAP_MAX_DURATION, 8'h11);
    wr(ADR_TAP_LATENCY, 8'h11);
    wr(ADR_SECOND_TAP_WINDOW, 8'h41);
    wr(ADR_TAP_AXIS_CONTROL, 8'h07);
    wr(ADR_EVENT_ENABLE, 8'h40);
    rd_chk("duration", ADR_TAP_MAX_DURATION, 8'hFF, 8'h11);
  endtask

  task automatic s_single();
    seq(16'hFC00, 16'h0000, 3, 0, 0);
    expect_ev(8'h01, 8'h00);
    chk("tap sign and axis", 8'h44, tap_info & 8'h47);
    rd_chk("first axis", ADR_FIRST_AXIS_STATUS, 8'h07, 8'h04);
    rd_chk("first axis again", ADR_FIRST_AXIS_STATUS, 8'h07, 8'h04);
    seq(16'h0400, 16'h0000, 20, 0, 0);
    expect_ev(8'h00, 8'h00);
  endtask

  task automatic s_axis();
    wr(ADR_TAP_AXIS_CONTROL, 8'h01);
    seq(16'h0400, 16'h0000, 3, 0, 0);
    expect_ev(8'h00, 8'h00);
    seq(16'h0000, 16'h0400, 3, 0, 0);
    expect_ev(8'h01, 8'h00);
    chk("z axis report", 8'h41, tap_info & 8'h47);
    wr(ADR_TAP_AXIS_CONTROL, 8'h07);
  endtask

  task automatic s_double();
    wr(ADR_EVENT_ENABLE, 8'h60);
    seq(16'h0400, 16'h0000, 3, 22, 3);
    expect_ev(8'h01, 8'h01);
    chk("paired events", 8'h01, 8'(n_pair - base_p));
    chk("report kind", 8'h01, {7'h00, tap_double});
    wr(ADR_EVENT_ENABLE, 8'h20);
    seq(16'h0400, 16'h0000, 3, 22, 3);
    expect_ev(8'h00, 8'h01);
  endtask

  task automatic s_reject();
    wr(ADR_EVENT_ENABLE, 8'h60);
    seq(16'h0400, 16'h0000, 3, 1, 40);
    expect_ev(8'h01, 8'h00);
    seq(16'h0400, 16'h0000, 3, 22, 20);
    expect_ev(8'h01, 8'h00);
    seq(16'h0400, 16'h0000, 3, 0, 0);
    expect_ev(8'h01, 8'h00);
    chk("report kind", 8'h00, {7'h00, tap_double});
  endtask

  task automatic s_suppress();
    wr(ADR_TAP_AXIS_CONTROL, 8'h0F);
    mark();
    hits(16'h0400, 16'h0000, 3);
    hits(16'h0000, 16'h0000, 2);
    hits(16'h0400, 16'h0000, 1);
    // Without suppress the later tap would pair into a double instead.
    hits(16'h0000, 16'h0000, 20);
    hits(16'h0400, 16'h0000, 3);
    hits(16'h0000, 16'h0000, 90);
    expect_ev(8'h02, 8'h00);
    wr(ADR_TAP_AXIS_CONTROL, 8'h07);
  endtask

  task automatic s_improved();
    wr(ADR_TAP_AXIS_CONTROL, 8'h17);
    wr(ADR_EVENT_ENABLE, 8'h40);
    step(16'h0000, 16'h0000, 1'b1);
    mark();
    hits(16'h0400, 16'h0000, 3);
    step(16'h0400, 16'h0000, 1'b1);
    repeat (4) step(16'h0400, 16'h0000, 1'b1);
    expect_ev(8'h01, 8'h00);
    wr(ADR_TAP_AXIS_CONTROL, 8'h07);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    sample_valid = 1'b0;
    odr_valid = 1'b0;
    accel = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    s_regs();
    s_single();
    s_axis();
    s_double();
    s_reject();
    s_suppress();
    s_improved();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
endmodule
